// File: dv/flash_self_program_sections_tb_top.sv
// Bench for the flash self-programming controller via a core model.
// Assumes a 20-cycle programming time; inputs change on falling edges.
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_sections_tb_top;
  localparam int PC = 20; // Short programming time keeps the run brief
  typedef struct {logic [1:0] op, al, bl; logic [12:0] pc, tgt; logic st;} fsps_row_t;
  // Op 0 erase, 1 write; fuse 0 puts the boot section at 1F80
  fsps_row_t rows[8] = '{
    '{2'h0, 2'h3, 2'h3, 13'h1F80, 13'h0100, 1'b1},
    '{2'h1, 2'h3, 2'h3, 13'h0100, 13'h0200, 1'b0},
    '{2'h1, 2'h3, 2'h3, 13'h1F7F, 13'h0000, 1'b0},
    '{2'h1, 2'h3, 2'h3, 13'h1F80, 13'h1C00, 1'b1},
    '{2'h1, 2'h3, 2'h3, 13'h1FFF, 13'h1F90, 1'b1},
    '{2'h0, 2'h2, 2'h3, 13'h1F80, 13'h0100, 1'b0},
    '{2'h1, 2'h3, 2'h2, 13'h1F80, 13'h1FC0, 1'b0},
    '{2'h0, 2'h2, 2'h3, 13'h1F80, 13'h1FC0, 1'b1}};
  logic        mclk = 0, rst = 1, go = 0, ren = 0, v, halt, busy, rv, act, st, rej, e;
  logic [1:0]  op = 2'h3, mop, fuse = 2'h0, al = 2'h3, bl = 2'h3;
  logic [12:0] pc = 13'h0000, tgt = 13'h0000, fetch = 13'h1C00, mpc, mtgt, ra, faddr;
  int          err_count = 0, cmp_count = 0, na, nh;
  always #50 mclk = ~mclk;
  fsps_core_model core (.I_MCLK(mclk), .i_go(go), .i_op(op), .i_pc(pc), .i_tgt(tgt),
    .i_fetch(fetch), .i_halt(halt), .o_spm_valid(v), .o_spm_op(mop), .o_spm_pc(mpc),
    .o_spm_target(mtgt), .o_read_addr(ra));
  fsps_ctrl #(.PROG_CYCLES(PC)) dut (.I_MCLK(mclk), .I_RESET(rst), .i_spm_valid(v),
    .i_spm_op(mop), .i_spm_pc(mpc), .i_spm_target(mtgt), .i_rww_read_enable(ren),
    .i_read_addr(ra), .i_boot_size_fuses(fuse), .i_app_lock(al), .i_boot_lock(bl),
    .o_cpu_halt(halt), .o_rewrite_area_busy_flag(busy), .o_read_valid(rv),
    .o_prog_active(act), .o_flash_start(st), .o_flash_addr(faddr), .o_spm_rejected(rej));
  // Shared compare; four-state equality so an unknown bit matches only an unknown bit
  task automatic chk(string nm, logic [12:0] exp, logic [12:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // One-cycle strobe; returns on the falling edge after it was taken
  task automatic issue(logic [1:0] o, logic [12:0] p, logic [12:0] t);
    @(negedge mclk);
    {go, op, pc, tgt} <= {1'b1, o, p, t};
    @(negedge mclk);
    go <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic clr;
    @(negedge mclk);
    ren <= 1'b1;
    @(negedge mclk);
    ren <= 1'b0;
  endtask
  // Bounded wait; counts active and halted cycles on the way
  task automatic wait_idle(output int a, output int h);
    a = 0;
    h = 0;
    for (int i = 0; i < 200 && act === 1'b1; i++) begin
      a++;
      h += int'(halt === 1'b1);
      @(negedge mclk);
    end
    if (act !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk("reset", 13'h0001, {halt, busy, act, st, rej, rv});
    $display("reset test done");
    foreach (rows[i]) begin
      {al, bl} <= {rows[i].al, rows[i].bl};
      e = rows[i].st && rows[i].tgt >= 13'h1C00;
      issue(rows[i].op, rows[i].pc, rows[i].tgt);
      chk("start_rej", {rows[i].st, ~rows[i].st}, {st, rej});
      if (rows[i].st) chk("addr", rows[i].tgt, faddr);
      chk("busy", rows[i].st & ~e, busy);
      wait_idle(na, nh);
      chk("active", rows[i].st ? PC : 0, na);
      chk("halt", e ? PC : 0, nh);
      clr();
      chk("busy_clr", 0, busy);
      $display("row %0d done", i);
    end
    {al, bl, fetch} <= {4'hF, 13'h0000};
    issue(2'h1, 13'h1F80, 13'h0040);
    chk("blocked_read", 0, rv);
    fetch <= 13'h1C00;
    clr(); // Read enable mid-programming has no effect
    chk("fixed_read", 13'h0001, {halt, rv});
    chk("busy_hold", 1, busy);
    issue(2'h0, 13'h1F80, 13'h0080);
    chk("busy_refuse", 13'h0001, {st, rej});
    wait_idle(na, nh);
    fetch <= 13'h0000;
    repeat (2) @(negedge mclk);
    chk("still_blocked", 13'h0002, {busy, rv});
    issue(2'h2, 13'h1F80, 13'h0040);
    @(negedge mclk);
    chk("load_clr", 13'h0001, {busy, rv});
    $display("rewrite region test done");
    issue(2'h1, 13'h1F80, 13'h1D00);
    {rst, fuse} <= 3'h7;
    repeat (2) @(negedge mclk);
    chk("mid_reset", 0, {halt, act, busy});
    rst <= 1'b0;
    issue(2'h0, 13'h1C00, 13'h0000);
    chk("fuse3_boot", 13'h0001, st);
    wait_idle(na, nh);
    $display("fuse test done");
    test_done();
  end
endmodule // flash_self_program_sections_tb_top
`default_nettype wire

// File: dv/fsps_core_model.sv
// Core model: issues store ops and fetch addresses to the controller.
// Assumes the bench raises i_go for one falling edge per operation.
`timescale 1ns/10ps
`default_nettype none
module fsps_core_model (
  input  wire logic        I_MCLK,
  input  wire logic        i_go,
  input  wire logic [1:0]  i_op,
  input  wire logic [12:0] i_pc,
  input  wire logic [12:0] i_tgt,
  input  wire logic [12:0] i_fetch,
  input  wire logic        i_halt,
  output logic             o_spm_valid,
  output logic [1:0]       o_spm_op,
  output logic [12:0]      o_spm_pc,
  output logic [12:0]      o_spm_target,
  output logic [12:0]      o_read_addr
);
  // A halted core issues no store op until released; fetch addresses still flow
  always @(negedge I_MCLK) begin
    o_spm_valid <= i_go & ~i_halt;
    o_spm_op <= i_go ? i_op : 2'h3;
    o_spm_pc <= i_pc;
    o_spm_target <= i_go ? i_tgt : ~o_spm_target; // Inverted when idle, so the old target recurs every second cycle
    o_read_addr <= i_fetch; // Blocked area read only to probe
  end
endmodule // fsps_core_model
`default_nettype wire

// File: rtl/fsps_ctrl.sv
// Flash self-programming controller: gates store ops, halts CPU, tracks busy.
// Assumes the core pulses I_SPM_VALID for one cycle per store operation.
// Operation
// - Store ops fetched from application section are ignored.
// - Erase or write starts only from store ops in boot section.
// - Boot-section store ops may target any flash address, boot included.
// - Section boundary comes from boot size fuses only.
// - Application section protection follows lock set zero.
// - Boot section protection follows lock set one.
// - Flash split into fixed rewrite and no-rewrite regions.
// - Programming rewrite region keeps CPU running, no-rewrite fetches allowed.
// - Programming no-rewrite region halts CPU for whole operation.
// - Region choice comes from target page, not read address.
// - Rewrite-region reads invalid during any programming.
// - Boot section always inside no-rewrite region.
// - Busy flag reads one while rewrite region blocked by rewrite-region programming.
// - Busy flag set when rewrite-region erase or write starts.
// - Busy cleared after completion by read-enable or boot-section page load.
`timescale 1ns/10ps
`default_nettype none
module fsps_ctrl #(
  parameter int ADDR_W      = fsps_pkg::ADDR_W,
  parameter int PROG_CYCLES = fsps_pkg::PROG_CYCLES
) (
  input  wire logic              I_MCLK,
  input  wire logic              I_RESET,
  input  wire logic              i_spm_valid,
  input  wire logic [1:0]        i_spm_op,
  input  wire logic [ADDR_W-1:0] i_spm_pc,
  input  wire logic [ADDR_W-1:0] i_spm_target,
  input  wire logic              i_rww_read_enable,
  input  wire logic [ADDR_W-1:0] i_read_addr,
  input  wire logic [1:0]        i_boot_size_fuses,
  input  wire logic [1:0]        i_app_lock,
  input  wire logic [1:0]        i_boot_lock,
  output logic                   o_cpu_halt,
  output logic                   o_rewrite_area_busy_flag,
  output logic                   o_read_valid,
  output logic                   o_prog_active,
  output logic                   o_flash_start,
  output logic [ADDR_W-1:0]      o_flash_addr,
  output logic                   o_spm_rejected
);
  fsps_pkg::fsps_state_t state;
  logic [31:0]       count;
  logic              pc_boot, pc_no_read_while_write_region, tgt_boot, tgt_no_read_while_write_region, rd_boot, rd_no_read_while_write_region;
  logic              write_locked, start_ok, is_prog;
  logic [1:0]        boot_size;
  logic              fuse_taken;

  // Fuses caught after reset release, held until next reset
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      boot_size  <= fsps_pkg::FUSE_RESET;
      fuse_taken <= 1'b0;
    end else if (!fuse_taken) begin
      boot_size  <= i_boot_size_fuses;
      fuse_taken <= 1'b1;
    end
  end

  fsps_region #(.ADDR_W(ADDR_W)) u_pc  (.i_addr(i_spm_pc), .i_boot_size(boot_size),
    .o_in_boot(pc_boot), .o_in_no_read_while_write_region(pc_no_read_while_write_region));
  fsps_region #(.ADDR_W(ADDR_W)) u_tgt (.i_addr(i_spm_target), .i_boot_size(boot_size),
    .o_in_boot(tgt_boot), .o_in_no_read_while_write_region(tgt_no_read_while_write_region));
  fsps_region #(.ADDR_W(ADDR_W)) u_rd  (.i_addr(i_read_addr), .i_boot_size(boot_size),
    .o_in_boot(rd_boot), .o_in_no_read_while_write_region(rd_no_read_while_write_region));

  // Lock pair bit 0 low means store may not write that section
  always_comb begin
    if (tgt_boot)
      write_locked = !i_boot_lock[0];
    else
      write_locked = !i_app_lock[0];
  end
  assign is_prog  = (i_spm_op == fsps_pkg::FSPS_OP_ERASE) ||
                    (i_spm_op == fsps_pkg::FSPS_OP_WRITE);
  // Only boot-resident code programs; any unlocked target accepted
  assign start_ok = i_spm_valid && is_prog && pc_boot && !write_locked &&
                    (state == fsps_pkg::FSPS_IDLE);

  // Sequencer: region chosen by target page, not by reader
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      state <= fsps_pkg::FSPS_IDLE;
      count <= 32'h0;
    end else begin
      case (state)
        fsps_pkg::FSPS_IDLE: begin
          if (start_ok) begin
            state <= tgt_no_read_while_write_region ? fsps_pkg::FSPS_PROG_NO_READ_WHILE_WRITE_REGION : fsps_pkg::FSPS_PROG_RWW;
            count <= 32'(PROG_CYCLES - 1);
          end
        end
        default: begin
          if (count == 32'h0)
            state <= fsps_pkg::FSPS_IDLE;
          else
            count <= count - 32'h1;
        end
      endcase
    end
  end

  // Launch pulse and target register
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      o_flash_start  <= 1'b0;
      o_flash_addr   <= '0;
      o_spm_rejected <= 1'b0;
    end else begin
      o_flash_start  <= start_ok;
      o_spm_rejected <= i_spm_valid && is_prog && !start_ok;
      if (start_ok)
        o_flash_addr <= i_spm_target;
    end
  end

  // Busy flag: rewrite-region start sets it, clears only after completion; set wins
  always_ff @(posedge I_MCLK) begin
    if (I_RESET)
      o_rewrite_area_busy_flag <= 1'b0;
    else if (start_ok && !tgt_no_read_while_write_region)
      o_rewrite_area_busy_flag <= 1'b1;
    else if (state == fsps_pkg::FSPS_IDLE &&
             (i_rww_read_enable ||
              (i_spm_valid && pc_boot && i_spm_op == fsps_pkg::FSPS_OP_LOAD)))
      o_rewrite_area_busy_flag <= 1'b0;
  end

  assign o_prog_active = (state != fsps_pkg::FSPS_IDLE);
  // Halt covers the whole no-rewrite operation only
  assign o_cpu_halt    = (state == fsps_pkg::FSPS_PROG_NO_READ_WHILE_WRITE_REGION);
  // Rewrite-region data invalid while blocked or programming
  assign o_read_valid  = rd_no_read_while_write_region ? !o_cpu_halt
                                 : !(o_rewrite_area_busy_flag || o_prog_active);

  AST_APP_IGNORED: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (i_spm_valid && !pc_boot) |=> !o_flash_start) else $error("store from app started");
  AST_START_BOOT: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    o_flash_start |-> $past(pc_boot)) else $error("start not from boot section");
  AST_RWW_NO_HALT: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (start_ok && !tgt_no_read_while_write_region) |=> !o_cpu_halt) else $error("halt on rewrite program");
  AST_NO_READ_WHILE_WRITE_REGION_HALT: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (start_ok && tgt_no_read_while_write_region) |=> o_cpu_halt[*8]) else $error("halt missing");
  AST_BUSY_SET: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (start_ok && !tgt_no_read_while_write_region) |=> o_rewrite_area_busy_flag) else $error("busy not set");
  AST_BUSY_HOLD: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (o_rewrite_area_busy_flag && !rd_no_read_while_write_region) |-> !o_read_valid) else $error("read valid busy");
  AST_NO_READ_PROG: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (o_prog_active && !rd_no_read_while_write_region) |-> !o_read_valid) else $error("rewrite read in program");
  AST_BUSY_CLEAR: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (!o_prog_active && i_rww_read_enable && !start_ok) |=> !o_rewrite_area_busy_flag)
    else $error("busy not cleared");
  AST_RELEASE: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (o_cpu_halt && count == 32'h0) |=> !o_cpu_halt) else $error("halt not released");
  // Checked on the live target and store pc: no fuse code may put boot code in the rewrite region
  AST_BOOT_IN_NO_READ_WHILE_WRITE_REGION: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (tgt_boot |-> tgt_no_read_while_write_region) and (pc_boot |-> pc_no_read_while_write_region))
    else $error("boot section outside no-read-while-write region");
  AST_LOCK_APP: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (i_spm_valid && !tgt_boot && !i_app_lock[0]) |-> !start_ok) else $error("app lock");
  AST_LOCK_BOOT: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (i_spm_valid && tgt_boot && !i_boot_lock[0]) |-> !start_ok) else $error("boot lock");

  COV_RWW: cover property (@(posedge I_MCLK) start_ok && !tgt_no_read_while_write_region);
  COV_NO_READ_WHILE_WRITE_REGION: cover property (@(posedge I_MCLK) start_ok && tgt_no_read_while_write_region);
  COV_SELF: cover property (@(posedge I_MCLK) start_ok && tgt_boot);
  COV_REJECT: cover property (@(posedge I_MCLK) o_spm_rejected);
endmodule // fsps_ctrl
`default_nettype wire

// File: rtl/fsps_pkg.sv
// Package for the flash self-programming section controller.
// Assumes a word-addressed program flash; sizes are defaults only.
package fsps_pkg;
  localparam int          ADDR_W        = 13;       // Flash word address width
  localparam logic [12:0] NO_READ_WHILE_WRITE_REGION_START    = 13'h1C00; // Fixed rewrite/no-rewrite split
  localparam logic [12:0] BOOT_BASE_0   = 13'h1F80; // Boot section start per fuse code
  localparam logic [12:0] BOOT_BASE_1   = 13'h1F00;
  localparam logic [12:0] BOOT_BASE_2   = 13'h1E00;
  localparam logic [12:0] BOOT_BASE_3   = 13'h1C00;
  localparam logic [1:0]  LOCK_RESET    = 2'h3;     // Unprogrammed lock pair
  localparam logic [1:0]  FUSE_RESET    = 2'h0;
  localparam int          PROG_TIME_US  = 4000;     // Page erase/write time
  localparam int          CLK_MHZ       = 10;
  localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {FSPS_OP_ERASE, FSPS_OP_WRITE, FSPS_OP_LOAD, FSPS_OP_NONE} fsps_op_t;
  typedef enum {FSPS_IDLE, FSPS_PROG_RWW, FSPS_PROG_NO_READ_WHILE_WRITE_REGION} fsps_state_t;
endpackage

// File: rtl/fsps_region.sv
// Section and region classifier for one flash word address.
// Assumes fuse value is stable; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module fsps_region #(
  parameter int ADDR_W = fsps_pkg::ADDR_W
) (
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [1:0]        i_boot_size,
  output logic                   o_in_boot,
  output logic                   o_in_no_read_while_write_region
);
  logic [ADDR_W-1:0] base;
  // Boundary from fuses only, never from runtime state
  always_comb begin
    case (i_boot_size)
      2'h0:    base = ADDR_W'(fsps_pkg::BOOT_BASE_0);
      2'h1:    base = ADDR_W'(fsps_pkg::BOOT_BASE_1);
      2'h2:    base = ADDR_W'(fsps_pkg::BOOT_BASE_2);
      default: base = ADDR_W'(fsps_pkg::BOOT_BASE_3);
    endcase
  end
  assign o_in_boot = (i_addr >= base);
  // Fixed split independent of fuses; every boot base lies at or above it
  assign o_in_no_read_while_write_region = (i_addr >= ADDR_W'(fsps_pkg::NO_READ_WHILE_WRITE_REGION_START));
endmodule // fsps_region
`default_nettype wire
